// [hw/rx_dv_map.svh]
// Register map, reset values, field positions and timing constants
`ifndef RX_DV_MAP_SVH
`define RX_DV_MAP_SVH

`define ADDR_CFG 8'h00
`define ADDR_ON 8'h04
`define ADDR_OFF 8'h05
`define ADDR_WLO 8'h06
`define ADDR_WHI 8'h07
`define ADDR_STR 8'h08
`define ADDR_STAT 8'h09

`define CFG_RST 16'h0000
`define ON_RST 16'hfebf
`define OFF_RST 16'hf37f
`define WLO_RST 12'h000
`define WHI_RST 12'h001
`define STR_RST 6'h3f
`define STR_OFF 6'h3f
`define TMR_TOP 16'hffff

`define CFG_SLICER 15
`define CFG_CONT 5
`define CFG_SINGLE 6

`define SETTLE_US 2200
`define DETEN_US 2600
`define CLK_MHZ 250
`define SEQ_W 20

`define LAST_PERIOD 2'd2
`define HCNT_MAX 13'h1fff

`endif

// [hw/rx_dv_pkg.sv]
// Types shared by the data-valid detector and its window counter
package rx_dv_pkg;

    typedef enum logic [1:0] {
        DET_IDLE,
        DET_EVAL,
        DET_HOLD
    } det_state_t;

    typedef struct packed {
        logic prev;
        logic seen;
        logic [12:0] hcnt;
        logic [1:0] per;
        logic ok;
        logic busy;
        logic done;
    } win_state_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] on_per;
        logic [15:0] off_per;
        logic [11:0] wlo;
        logic [11:0] whi;
        logic [5:0] str_th;
        logic [15:0] rdata;
        logic rx_prev;
        logic [19:0] seq;
        logic settled;
        logic peak_en;
        logic pk_off;
        logic det_en;
        det_state_t dst;
        logic start;
        logic valid;
        logic done;
        logic str_ok;
        logic [15:0] tmr;
        logic poll_on;
    } top_state_t;

endpackage

// [hw/win_if.sv]
// Link between the detector control and the window counter
`timescale 1ns/1ps
`default_nettype none

interface win_if;
    logic data;
    logic tick;
    logic start;
    logic [11:0] lo;
    logic [11:0] hi;
    logic done;
    logic rate_ok;

    modport ctl (
        output data,
        output tick,
        output start,
        output lo,
        output hi,
        input done,
        input rate_ok
    );

    modport cnt (
        input data,
        input tick,
        input start,
        input lo,
        input hi,
        output done,
        output rate_ok
    );
endinterface

`default_nettype wire

// [hw/window_counter.sv]
// High-time window counter: three data periods per evaluation
`timescale 1ns/1ps
`default_nettype none
`include "rx_dv_map.svh"

module window_counter (
    input wire logic sys_clk,
    input wire logic resetn,
    win_if.cnt w
);
    rx_dv_pkg::win_state_t s;
    rx_dv_pkg::win_state_t n;

    function automatic logic in_win(
        input logic [12:0] h,
        input logic [12:0] lo,
        input logic [12:0] hi
    );
        in_win = (h >= lo) && (h <= hi);
    endfunction

    always_comb begin
        n = s;
        n.done = 1'b0;
        n.prev = w.data;
        if (w.start) begin
            n.busy = 1'b1;
            n.seen = 1'b0;
            n.per = 2'd0;
            n.ok = 1'b1;
            n.hcnt = 13'h0;
        end else if (s.busy) begin
            // A high phase already running at start is partial, so wait for a rise
            if (w.data && !s.prev) begin
                n.seen = 1'b1;
                n.hcnt = 13'h0;
            end else if (w.data && w.tick && s.hcnt != `HCNT_MAX) begin
                n.hcnt = s.hcnt + 13'd1;
            end
            if (!w.data && s.prev && s.seen) begin
                // Single or doubled high time both match for Manchester
                n.ok = s.ok && (in_win(s.hcnt, {1'b0, w.lo}, {1'b0, w.hi})
                    || in_win(s.hcnt, {w.lo, 1'b0}, {w.hi, 1'b0}));
                n.per = s.per + 2'd1;
                if (s.per == `LAST_PERIOD) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign w.done = s.done;
    assign w.rate_ok = s.ok;
endmodule

`default_nettype wire

// [hw/rx_data_valid_detector.sv]
// Receiver slicer select, peak detector sequencing, data-valid detection
// Function
// - Allow fixed 2.2 ms offset settling after power-on or any RX/TX switch.
// - Config bit 15 picks slicer threshold: 0 integrator, 1 peak detectors; reset 0.
// - Peak detector outputs stay active whatever slicer source is chosen.
// - Peak detectors enabled only after the whole receive path is on.
// - Peak detectors off: positive output forced low, negative output forced high.
// - Valid data needs both the data-rate check and the strength check.
// - Config bits 5 and 6 choose continuous or single-shot detection.
// - Detection enable rises about 2.6 ms after receive starts; idle before.
// - On window-complete edge latch strength compare and combine with rate result.
// - Continuous mode is ready for the next evaluation after three data periods.
// - Data rate measured from high time; single or double high time accepted.
// - A rate decision spans three full data periods.
// - Window bounds reset to zero and one, meaning window counter inactive.
// - Strength bound resets to all ones, disabling the strength criterion.
// - Poll ON and OFF periods are 16 bits, counted up to overflow.
// - Poll ON period resets to 65215 and OFF period to 62335.
`timescale 1ns/1ps
`default_nettype none
`include "rx_dv_map.svh"

module rx_data_valid_detector #(
    parameter int OFFSET_SETTLE_CYC = `SETTLE_US * `CLK_MHZ,
    parameter int DETECT_EN_CYC = `DETEN_US * `CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic rx_active,
    input wire logic rx_data,
    input wire logic xtal_quarter_tick,
    input wire logic [5:0] strength_code,
    input wire logic rc_tick,
    output logic slicer_peak_select,
    output logic offset_settled,
    output logic peak_det_enable,
    output logic pos_peak_force_low,
    output logic neg_peak_force_high,
    output logic detect_enable,
    output logic data_valid,
    output logic eval_done,
    output logic poll_on_phase
);
    localparam logic [19:0] SETTLE_N = 20'(OFFSET_SETTLE_CYC);
    localparam logic [19:0] DETEN_N = 20'(DETECT_EN_CYC);

    localparam rx_dv_pkg::top_state_t RST = '{
        cfg: `CFG_RST,
        on_per: `ON_RST,
        off_per: `OFF_RST,
        wlo: `WLO_RST,
        whi: `WHI_RST,
        str_th: `STR_RST,
        rdata: 16'h0000,
        rx_prev: 1'b0,
        seq: 20'h00000,
        settled: 1'b0,
        peak_en: 1'b0,
        pk_off: 1'b1,
        det_en: 1'b0,
        dst: rx_dv_pkg::DET_IDLE,
        start: 1'b0,
        valid: 1'b0,
        done: 1'b0,
        str_ok: 1'b0,
        tmr: `ON_RST,
        poll_on: 1'b1
    };

    rx_dv_pkg::top_state_t s;
    rx_dv_pkg::top_state_t n;

    win_if w ();

    window_counter window_counter_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .w(w.cnt)
    );

    assign w.data = rx_data;
    assign w.tick = xtal_quarter_tick;
    assign w.start = s.start;
    assign w.lo = s.wlo;
    assign w.hi = s.whi;

    function automatic logic [15:0] reg_read(
        input logic [7:0] a,
        input rx_dv_pkg::top_state_t st
    );
        case (a)
            `ADDR_CFG: reg_read = st.cfg;
            `ADDR_ON: reg_read = st.on_per;
            `ADDR_OFF: reg_read = st.off_per;
            `ADDR_WLO: reg_read = {4'h0, st.wlo};
            `ADDR_WHI: reg_read = {4'h0, st.whi};
            `ADDR_STR: reg_read = {10'h000, st.str_th};
            `ADDR_STAT: reg_read = {8'h00, st.str_ok, st.valid, st.dst,
                st.det_en, st.peak_en, st.settled, st.poll_on};
            default: reg_read = 16'h0000;
        endcase
    endfunction

    logic mode_on;
    logic single;
    logic win_active;

    always_comb begin
        n = s;
        n.start = 1'b0;
        n.done = 1'b0;
        n.rdata = 16'h0000;
        mode_on = s.cfg[`CFG_CONT] | s.cfg[`CFG_SINGLE];
        single = s.cfg[`CFG_SINGLE];
        // Reset bounds mean the counter is parked; no evaluation starts
        win_active = !(s.wlo == `WLO_RST && s.whi == `WHI_RST);

        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CFG: n.cfg = reg_wdata;
                `ADDR_ON: n.on_per = reg_wdata;
                `ADDR_OFF: n.off_per = reg_wdata;
                `ADDR_WLO: n.wlo = reg_wdata[11:0];
                `ADDR_WHI: n.whi = reg_wdata[11:0];
                `ADDR_STR: n.str_ok = s.str_ok;
                default: n.cfg = s.cfg;
            endcase
            if (reg_addr == `ADDR_STR) begin
                n.str_th = reg_wdata[5:0];
            end
        end
        if (reg_rd) begin
            n.rdata = reg_read(reg_addr, s);
        end

        // Any receive/transmit switch restarts the settling clock
        n.rx_prev = rx_active;
        if (rx_active != s.rx_prev) begin
            n.seq = 20'h00000;
        end else if (s.seq < DETEN_N) begin
            n.seq = s.seq + 20'd1;
        end
        // Judge the cleared count, so a switch never leaves one stale settled cycle
        n.settled = (n.seq >= SETTLE_N);
        // Peak detectors run regardless of the slicer choice
        n.peak_en = rx_active && (n.seq >= SETTLE_N);
        n.pk_off = !n.peak_en;
        n.det_en = rx_active && (n.seq >= DETEN_N);

        case (s.dst)
            rx_dv_pkg::DET_IDLE: begin
                if (s.det_en && mode_on && win_active) begin
                    n.start = 1'b1;
                    n.dst = rx_dv_pkg::DET_EVAL;
                end
            end
            rx_dv_pkg::DET_EVAL: begin
                if (w.done) begin
                    n.str_ok = (s.str_th == `STR_OFF)
                        || (strength_code >= s.str_th);
                    n.valid = w.rate_ok && n.str_ok;
                    n.done = 1'b1;
                    if (single) begin
                        n.dst = rx_dv_pkg::DET_HOLD;
                    end else begin
                        n.start = 1'b1;
                    end
                end
            end
            rx_dv_pkg::DET_HOLD: begin
                n.dst = rx_dv_pkg::DET_HOLD;
            end
            default: begin
                n.dst = rx_dv_pkg::DET_IDLE;
            end
        endcase
        // A config write re-arms single shot; losing enable drops the result
        if (reg_wr && reg_addr == `ADDR_CFG) begin
            n.dst = rx_dv_pkg::DET_IDLE;
            n.start = 1'b0;
        end
        if (!s.det_en) begin
            n.dst = rx_dv_pkg::DET_IDLE;
            n.start = 1'b0;
            n.valid = 1'b0;
        end

        // Poll timer counts up from the loaded period to overflow
        if (rc_tick) begin
            if (s.tmr == `TMR_TOP) begin
                n.poll_on = !s.poll_on;
                n.tmr = s.poll_on ? s.off_per : s.on_per;
            end else begin
                n.tmr = s.tmr + 16'd1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign slicer_peak_select = s.cfg[`CFG_SLICER];
    assign offset_settled = s.settled;
    assign peak_det_enable = s.peak_en;
    assign pos_peak_force_low = s.pk_off;
    assign neg_peak_force_high = s.pk_off;
    assign detect_enable = s.det_en;
    assign data_valid = s.valid;
    assign eval_done = s.done;
    assign poll_on_phase = s.poll_on;
endmodule

`default_nettype wire

// [tb/rx_dv_assertions.sv]
// Port checker for the data-valid detector
`timescale 1ns/1ps
`default_nettype none
module rx_dv_assertions (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic rx_active,
    input wire logic rc_tick,
    input wire logic slicer_peak_select,
    input wire logic offset_settled,
    input wire logic peak_det_enable,
    input wire logic pos_peak_force_low,
    input wire logic neg_peak_force_high,
    input wire logic detect_enable,
    input wire logic data_valid,
    input wire logic eval_done,
    input wire logic poll_on_phase
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence rx_on;
        $rose(rx_active);
    endsequence
    sequence cfg_wr;
        reg_wr && reg_addr == 8'h00;
    endsequence
    force_low_a: assert property (pos_peak_force_low != peak_det_enable)
        else $error("positive peak output not forced");
    force_high_a: assert property (neg_peak_force_high != peak_det_enable)
        else $error("negative peak output not forced");
    peak_order_a: assert property (peak_det_enable |-> offset_settled)
        else $error("peak detectors on before path settled");
    settle_wait_a: assert property (rx_on |=> !offset_settled [*8])
        else $error("settling cut short");
    detect_wait_a: assert property (detect_enable |-> offset_settled)
        else $error("detection enabled too early");
    slicer_sel_a: assert property (cfg_wr |=> slicer_peak_select == $past(reg_wdata[15]))
        else $error("slicer select not taken from write");
    eval_gap_a: assert property (eval_done |=> !eval_done [*4])
        else $error("evaluations too close");
    valid_rise_a: assert property ($rose(data_valid) |-> eval_done || $past(eval_done))
        else $error("valid rose outside an evaluation end");
    valid_clear_a: assert property ($fell(detect_enable) |=> !data_valid)
        else $error("valid kept after detection stopped");
    poll_tick_a: assert property ($changed(poll_on_phase) |-> $past(rc_tick))
        else $error("poll phase moved without a tick");
endmodule
bind rx_data_valid_detector rx_dv_assertions rx_dv_assertions_i (.sys_clk, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .rx_active, .rc_tick, .slicer_peak_select,
    .offset_settled, .peak_det_enable, .pos_peak_force_low, .neg_peak_force_high,
    .detect_enable, .data_valid, .eval_done, .poll_on_phase);
`default_nettype wire

// [tb/rx_data_valid_detector_test.sv]
// Self-checking bench for the data-valid detector
`timescale 1ns/1ps
`default_nettype none
`include "rx_dv_map.svh"
module rx_data_valid_detector_test;
    logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, rx_active = 0, rx_data = 0;
    logic rc_tick = 0, xtal_quarter_tick = 1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [5:0] strength_code = 6'h00;
    wire logic [15:0] reg_rdata;
    wire logic slicer_peak_select, offset_settled, peak_det_enable, pos_peak_force_low;
    wire logic neg_peak_force_high, detect_enable, data_valid, eval_done, poll_on_phase;
    int err_total = 0, n_compared = 0, n_done = 0, n;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (eval_done === 1'b1) n_done <= n_done + 1;
    // Short settle counts keep the run brief; ordering of the two is kept
    rx_data_valid_detector #(.OFFSET_SETTLE_CYC(20), .DETECT_EN_CYC(40)) rx_data_valid_detector_i (
        .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_active,
        .rx_data, .xtal_quarter_tick, .strength_code, .rc_tick, .slicer_peak_select,
        .offset_settled, .peak_det_enable, .pos_peak_force_low, .neg_peak_force_high,
        .detect_enable, .data_valid, .eval_done, .poll_on_phase);
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        // Read data stand for one cycle only
        @(posedge sys_clk);
        #1 chk(reg_rdata, 16'h0000);
    endtask
    // Waits on settled (0), detect (1) or poll off phase (2), bounded
    task automatic wt(input int sel, input int lim, output int c);
        logic [2:0] v;
        c = 0;
        v = 3'b000;
        while (v[sel] !== 1'b1) begin
            @(negedge sys_clk);
            c++;
            v = {~poll_on_phase, detect_enable, offset_settled};
            if (c > lim) begin
                err_total++;
                final_report();
            end
        end
    endtask
    task automatic t_poll();
        @(posedge sys_clk);
        rc_tick <= 1'b1;
        wt(2, 400, n);
        chk(n >= 320 && n <= 322, 1);
        @(posedge sys_clk);
        rc_tick <= 1'b0;
    endtask
    task automatic t_regs();
        rd(`ADDR_ON, `ON_RST);
        rd(`ADDR_OFF, `OFF_RST);
        rd(`ADDR_WLO, 16'h0000);
        rd(`ADDR_WHI, 16'h0001);
        rd(`ADDR_STR, 16'h003f);
        rd(`ADDR_CFG, 16'h0000);
        rd(8'h0a, 16'h0000);
        wr(`ADDR_ON, 16'hffff);
        rd(`ADDR_ON, 16'hffff);
        chk(slicer_peak_select, 0);
        wr(`ADDR_CFG, 16'h8000);
        rd(`ADDR_CFG, 16'h8000);
        chk(slicer_peak_select, 1);
    endtask
    task automatic t_seq();
        chk(pos_peak_force_low, 1);
        chk(neg_peak_force_high, 1);
        @(posedge sys_clk);
        rx_active <= 1'b1;
        // Settling left from power-on is dropped by the switch first
        repeat (2) @(negedge sys_clk);
        chk(offset_settled, 0);
        chk(peak_det_enable, 0);
        wt(0, 60, n);
        chk(n, 20);
        @(negedge sys_clk);
        chk(peak_det_enable, 1);
        chk(pos_peak_force_low, 0);
        chk(neg_peak_force_high, 0);
        wt(1, 60, n);
        chk(n, 19);
        rd(`ADDR_STAT, 16'h000e);
    endtask
    // One evaluation run: h cycles high and low, p periods
    task automatic ev(input logic [15:0] cfg, input int h, input int p, input logic [5:0] s,
                      input logic v, output int nd);
        int base;
        base = n_done;
        wr(`ADDR_CFG, cfg);
        strength_code <= s;
        repeat (2 * p) begin
            repeat (h) @(posedge sys_clk);
            rx_data <= ~rx_data;
        end
        repeat (8) @(posedge sys_clk);
        #1 chk(data_valid, v);
        nd = n_done - base;
    endtask
    task automatic t_eval();
        ev(16'h0040, 10, 4, 6'h00, 1'b0, n);
        chk(n, 0);
        wr(`ADDR_WLO, 16'h0008);
        wr(`ADDR_WHI, 16'h000c);
        ev(16'h0040, 10, 4, 6'h00, 1'b1, n);
        chk(n, 1);
        wr(`ADDR_STR, 16'h0010);
        ev(16'h0040, 20, 4, 6'h20, 1'b1, n);
        ev(16'h0040, 14, 4, 6'h20, 1'b0, n);
        ev(16'h0040, 10, 4, 6'h10, 1'b1, n);
        ev(16'h0040, 10, 4, 6'h0f, 1'b0, n);
        ev(16'h0060, 10, 10, 6'h20, 1'b1, n);
        chk(n, 1);
        ev(16'h0020, 10, 10, 6'h20, 1'b1, n);
        chk(n >= 2, 1);
        chk(pos_peak_force_low, 0);
    endtask
    task automatic t_off();
        @(posedge sys_clk);
        rx_active <= 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(detect_enable, 0);
        chk(offset_settled, 0);
        chk(data_valid, 0);
        chk(pos_peak_force_low, 1);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_poll();
        t_regs();
        t_seq();
        t_eval();
        t_off();
        final_report();
    end
endmodule
`default_nettype wire
